// file: verilog/emcfe_map.svh
// Offsets-free constant map of the memory control front end.
// Assumes inclusion by the package and the top module only.
`ifndef EMCFE_MAP_SVH
`define EMCFE_MAP_SVH
// Word-address field that picks the memory space
`define EMCFE_SPACE_MSB 31
`define EMCFE_SPACE_LSB 28
// Space codes of word-address bits 31..28
`define EMCFE_SPACE0_CODE 4'h8
`define EMCFE_SPACE1_CODE 4'h9
`define EMCFE_SPACE2_CODE 4'hA
`define EMCFE_SPACE3_CODE 4'hB
// Access size codes
`define EMCFE_SIZE_BYTE 2'h0
`define EMCFE_SIZE_HALF 2'h1
`define EMCFE_SIZE_WORD 2'h2
// Timing counts in core clock cycles, and counter width in bits
`define EMCFE_ACC_CYCLES 4
`define EMCFE_CLK3_HALF 2
`define EMCFE_CNT_W 4
// Reset values of config inputs when software does not steer them
`define EMCFE_CLK_SRC_RST 1'b0
`define EMCFE_CLK_EN_RST 1'b1
`endif

// file: verilog/emcfe_pkg.sv
// Types of the memory control front end.
// Assumes the constant map is on the include path.
`include "emcfe_map.svh"
package emcfe_pkg;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ACCESS,
    ST_HELD
  } emcfe_state_t;

  typedef struct packed {
    emcfe_state_t st;
    logic [3:0] cs_n;
    logic be_hi_n;
    logic be_lo_n;
    logic ctl_oe;
    logic ack;
    logic need;
    logic done;
    logic ready;
    logic [`EMCFE_CNT_W-1:0] cnt;
    logic [2:0] hreq_sync;
    logic hreq;
    logic [2:0] ck_sync;
    logic ck_in;
    logic [`EMCFE_CNT_W-1:0] div_cnt;
    logic div_clk;
    logic clk_out;
  } emcfe_regs_t;
endpackage

// file: verilog/emcfe_top.sv
// Control signal front end of a 16-bit external memory interface.
// Assumes one core clock, pins synchronised here, config from the core.
`timescale 1ns/1ps
`include "emcfe_map.svh"
module emcfe_top
  import emcfe_pkg::*;
#(
  parameter int ACC_CYCLES = `EMCFE_ACC_CYCLES,
  parameter int CLK3_HALF = `EMCFE_CLK3_HALF
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Core access request
  input wire logic acc_req,
  input wire logic [31:0] acc_word_addr,
  input wire logic [1:0] acc_byte_addr,
  input wire logic [1:0] acc_size,
  output logic acc_ready,
  output logic acc_done,
  // Memory space enables, active low, three-state
  output logic mem_space_sel_0_n,
  output logic mem_space_sel_1_n,
  output logic mem_space_sel_2_n,
  output logic mem_space_sel_3_n,
  output logic mem_space_sel_oe,
  // Byte enables, active low, three-state
  output logic byte_lane_en_hi_n,
  output logic byte_lane_en_lo_n,
  output logic byte_lane_en_oe,
  // Bus arbitration
  input wire logic bus_takeover_req,
  output logic bus_takeover_ack,
  output logic bus_need_out,
  // Memory clock
  input wire logic mem_clk_in,
  input wire logic mem_clk_src_sel,
  input wire logic mem_clk_out_en,
  output logic mem_clk_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Decoders

  function automatic logic [3:0] space_dec(input logic [3:0] code);
    logic [3:0] sel;
    sel = 4'h0;
    unique case (code)
      `EMCFE_SPACE0_CODE: sel = 4'h1;
      `EMCFE_SPACE1_CODE: sel = 4'h2;
      `EMCFE_SPACE2_CODE: sel = 4'h4;
      `EMCFE_SPACE3_CODE: sel = 4'h8;
      default: sel = 4'h0;
    endcase
    return sel;
  endfunction

  // Returns {hi, lo} active high
  function automatic logic [1:0] lane_dec(input logic [1:0] size,
                                          input logic [1:0] addr);
    logic [1:0] en;
    en = 2'h3;
    if (size == `EMCFE_SIZE_BYTE) begin
      en = addr[0] ? 2'h2 : 2'h1;
    end
    return en;
  endfunction

  localparam int CNT_W = `EMCFE_CNT_W;
  localparam logic [CNT_W-1:0] ACC_LAST = CNT_W'(ACC_CYCLES - 1);
  localparam logic [CNT_W-1:0] HALF_LAST = CNT_W'(CLK3_HALF - 1);

  emcfe_regs_t r_ff;
  emcfe_regs_t nxt_r;

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic [1:0] lanes;
    lanes = lane_dec(acc_size, acc_byte_addr);
    nxt_r = r_ff;
    nxt_r.done = 1'b0;
    // Pin synchronisers: a change counts once stages 2 and 3 agree
    nxt_r.hreq_sync = {r_ff.hreq_sync[1:0], bus_takeover_req};
    if (r_ff.hreq_sync[1] == r_ff.hreq_sync[2]) begin
      nxt_r.hreq = r_ff.hreq_sync[2];
    end
    nxt_r.ck_sync = {r_ff.ck_sync[1:0], mem_clk_in};
    if (r_ff.ck_sync[1] == r_ff.ck_sync[2]) begin
      nxt_r.ck_in = r_ff.ck_sync[2];
    end
    // Internal third system clock divider
    if (r_ff.div_cnt == HALF_LAST) begin
      nxt_r.div_cnt = '0;
      nxt_r.div_clk = ~r_ff.div_clk;
    end else begin
      nxt_r.div_cnt = r_ff.div_cnt + 1'b1;
    end
    if (!mem_clk_out_en) begin
      nxt_r.clk_out = 1'b0;
    end else if (mem_clk_src_sel) begin
      nxt_r.clk_out = r_ff.ck_in;
    end else begin
      nxt_r.clk_out = r_ff.div_clk;
    end
    unique case (r_ff.st)
      ST_IDLE: begin
        if (r_ff.hreq) begin
          nxt_r.st = ST_HELD;
          nxt_r.ack = 1'b1;
          nxt_r.ctl_oe = 1'b0;
        end else if (acc_req && r_ff.ready) begin
          // Refused while ready is low, also in the cycle after reset
          nxt_r.st = ST_ACCESS;
          nxt_r.cnt = ACC_LAST;
          nxt_r.cs_n = ~space_dec(
            acc_word_addr[`EMCFE_SPACE_MSB:`EMCFE_SPACE_LSB]);
          nxt_r.be_hi_n = ~lanes[1];
          nxt_r.be_lo_n = ~lanes[0];
        end
      end
      ST_ACCESS: begin
        if (r_ff.cnt == '0) begin
          nxt_r.st = ST_IDLE;
          nxt_r.done = 1'b1;
          nxt_r.cs_n = 4'hF;
          nxt_r.be_hi_n = 1'b1;
          nxt_r.be_lo_n = 1'b1;
        end else begin
          nxt_r.cnt = r_ff.cnt - 1'b1;
        end
      end
      ST_HELD: begin
        nxt_r.need = acc_req;
        if (!r_ff.hreq) begin
          nxt_r.st = ST_IDLE;
          nxt_r.ack = 1'b0;
          nxt_r.ctl_oe = 1'b1;
          nxt_r.need = 1'b0;
        end
      end
    endcase
    nxt_r.ready = (nxt_r.st == ST_IDLE) && !nxt_r.hreq;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      r_ff <= '{st: ST_IDLE, cs_n: 4'hF, be_hi_n: 1'b1, be_lo_n: 1'b1,
                ctl_oe: 1'b1, ack: 1'b0, need: 1'b0, done: 1'b0,
                ready: 1'b0, cnt: '0, hreq_sync: 3'h0, hreq: 1'b0,
                ck_sync: 3'h0, ck_in: 1'b0, div_cnt: '0, div_clk: 1'b0,
                clk_out: 1'b0};
    end else begin
      r_ff <= nxt_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign acc_ready = r_ff.ready;
  assign acc_done = r_ff.done;
  assign mem_space_sel_0_n = r_ff.cs_n[0];
  assign mem_space_sel_1_n = r_ff.cs_n[1];
  assign mem_space_sel_2_n = r_ff.cs_n[2];
  assign mem_space_sel_3_n = r_ff.cs_n[3];
  assign mem_space_sel_oe = r_ff.ctl_oe;
  assign byte_lane_en_hi_n = r_ff.be_hi_n;
  assign byte_lane_en_lo_n = r_ff.be_lo_n;
  assign byte_lane_en_oe = r_ff.ctl_oe;
  assign bus_takeover_ack = r_ff.ack;
  assign bus_need_out = r_ff.need;
  assign mem_clk_out = r_ff.clk_out;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  wire logic take = acc_req && acc_ready;

  a_space_decode: assert property (take |=>
    r_ff.cs_n == ~space_dec(
    $past(acc_word_addr[`EMCFE_SPACE_MSB:`EMCFE_SPACE_LSB])))
    else $error("space enable does not match address");
  a_one_space: assert property ($countones(~r_ff.cs_n) <= 1)
    else $error("more than one space enable active");
  a_lane_decode: assert property (take |=>
    {r_ff.be_hi_n, r_ff.be_lo_n} ==
    ~lane_dec($past(acc_size), $past(acc_byte_addr)))
    else $error("byte enables do not match address");
  a_lane_hold: assert property (take ##1 r_ff.st == ST_ACCESS
    |=> $stable({r_ff.be_hi_n, r_ff.be_lo_n}) [*2])
    else $error("byte enables moved during access");
  a_clk_internal: assert property (mem_clk_out_en
    && !mem_clk_src_sel |=> mem_clk_out == $past(r_ff.div_clk))
    else $error("output clock not from internal clock");
  a_clk_external: assert property (mem_clk_out_en
    && mem_clk_src_sel |=> mem_clk_out == $past(r_ff.ck_in))
    else $error("output clock not from input pin");
  a_clk_low: assert property (!mem_clk_out_en |=> !mem_clk_out)
    else $error("output clock not held low");
  a_clk_runs: assert property (
    (mem_clk_out_en && !mem_clk_src_sel) [*6] |-> !$stable(mem_clk_out)
    || ($past(mem_clk_out) != $past(mem_clk_out, 2))
    || ($past(mem_clk_out, 2) != $past(mem_clk_out, 3)))
    else $error("enabled output clock does not toggle");
  a_hold_ack: assert property ($rose(r_ff.hreq) |-> ##[1:20]
    bus_takeover_ack)
    else $error("takeover request not acknowledged");
  a_hold_float: assert property (bus_takeover_ack |->
    !mem_space_sel_oe && !byte_lane_en_oe && r_ff.cs_n == 4'hF
    && !acc_ready)
    else $error("controls driven while bus taken over");

  c_access: cover property (take ##[1:20] acc_done);
  c_takeover: cover property ($rose(bus_takeover_ack)
    ##[1:50] $fell(bus_takeover_ack));
  c_need: cover property (bus_need_out);
  c_ext_clk: cover property (mem_clk_src_sel && $rose(mem_clk_out));

endmodule

// file: sim/emcfe_host_model.sv
// Host partner: bus takeover requester and free-running memory clock pin.
// Assumes the bench steers the takeover wish; pin clock is 160 ns.
`timescale 1ns/1ps
module emcfe_host_model (
  // Bench control
  input wire logic want_bus,
  // Host pins
  output logic bus_takeover_req,
  output logic mem_clk_in
);
  // Phase offset keeps the pin clock unrelated to the core clock
  initial begin
    mem_clk_in = 1'b0;
    #7;
    forever #80 mem_clk_in = ~mem_clk_in;
  end
  assign bus_takeover_req = want_bus;
endmodule

// file: sim/ext_mem_ctrl_signal_front_end_test.sv
// Bench of the memory control front end against a behavioural model.
// Assumes default access length and internal clock divider.
`timescale 1ns/1ps
module ext_mem_ctrl_signal_front_end_test;
  import emcfe_pkg::*;
  localparam int ACC = 4;
  logic core_clk = 1'b0, rst_n = 1'b0, acc_req = 1'b0;
  logic src = 1'b0, en = 1'b1, want = 1'b0;
  logic [31:0] wa = 32'h0, r;
  logic [1:0] ba = 2'h0, sz = 2'h0;
  logic rdy, done, c0, c1, c2, c3, coe, bh, bl, boe, req, ack, need;
  logic ckin, ckout;
  int mismatches = 0, n_compared = 0, seed = 29, i, k, tg;
  logic [3:0] codes [5] = '{4'h8, 4'h9, 4'hA, 4'hB, 4'h3};
  emcfe_top u_emcfe_top (.core_clk(core_clk), .rst_n(rst_n),
    .acc_req(acc_req), .acc_word_addr(wa), .acc_byte_addr(ba),
    .acc_size(sz), .acc_ready(rdy), .acc_done(done),
    .mem_space_sel_0_n(c0), .mem_space_sel_1_n(c1),
    .mem_space_sel_2_n(c2), .mem_space_sel_3_n(c3),
    .mem_space_sel_oe(coe), .byte_lane_en_hi_n(bh),
    .byte_lane_en_lo_n(bl), .byte_lane_en_oe(boe),
    .bus_takeover_req(req), .bus_takeover_ack(ack), .bus_need_out(need),
    .mem_clk_in(ckin), .mem_clk_src_sel(src), .mem_clk_out_en(en),
    .mem_clk_out(ckout));
  emcfe_host_model u_emcfe_host_model (.want_bus(want),
    .bus_takeover_req(req), .mem_clk_in(ckin));
  initial begin
    forever #10 core_clk = ~core_clk;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string m);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic close_out;
    $display("mismatches=%0d n_compared=%0d", mismatches, n_compared);
    if (mismatches == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic wait_on(input logic [1:0] sel, input logic lvl);
    k = 0;
    while ((sel == 0 ? rdy : ack) !== lvl && k < 50) begin
      step(1);
      k++;
    end
    if ((sel == 0 ? rdy : ack) !== lvl) begin
      chk(8'h0, 8'h1, "wait bound ran out");
      close_out();
    end
  endtask
  // Model: one space enable per mapped code, none otherwise
  function automatic logic [3:0] exp_cs(input logic [3:0] nib);
    exp_cs = 4'hF;
    if (nib >= 4'h8 && nib <= 4'hB) exp_cs[nib - 4'h8] = 1'b0;
  endfunction
  task automatic access(input int n);
    logic [7:0] ex;
    wait_on(0, 1'b1);
    r = $random(seed);
    wa = {codes[n % 5], r[31:4]};
    sz = r[1:0];
    ba = r[3:2];
    acc_req = 1'b1;
    step(1);
    acc_req = 1'b0;
    ex = {4'h0, exp_cs(wa[31:28])};
    chk({4'h0, c3, c2, c1, c0}, ex, "space");
    ex = sz == 2'h0 ? (ba[0] ? 8'h1 : 8'h2) : 8'h0;
    chk({bh, bl}, ex, "lanes");
    step(ACC);
    chk({done, c3, c2, c1, c0, bh, bl}, 8'h7F, "done");
  endtask
  task automatic count_edges(input int n);
    logic last;
    last = ckout;
    tg = 0;
    repeat (n) begin
      step(1);
      if (ckout !== last) tg++;
      last = ckout;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    step(16);
    chk({c3, c2, c1, c0, ack, done, rdy, ckout}, 8'hF0, "reset");
    rst_n = 1'b1;
    for (i = 0; i < 20; i++) access(i);
    want = 1'b1;
    wait_on(1, 1'b1);
    chk({ack, coe, boe, rdy}, 8'h8, "hold float");
    acc_req = 1'b1;
    step(2);
    chk(need, 8'h1, "need shown");
    chk({c3, c2, c1, c0}, 8'hF, "no access held");
    acc_req = 1'b0;
    want = 1'b0;
    wait_on(1, 1'b0);
    wait_on(0, 1'b1);
    chk({coe, boe, c3, c2, c1, c0, need}, 8'h7E, "released");
    access(1);
    en = 1'b0;
    step(2);
    count_edges(40);
    chk({ckout, 7'(tg)}, 8'h0, "clk held low");
    en = 1'b1;
    count_edges(80);
    chk(tg >= 39 && tg <= 41, 8'h1, "internal clock");
    src = 1'b1;
    step(8);
    count_edges(80);
    chk(tg >= 19 && tg <= 21, 8'h1, "pin clock");
    en = 1'b0;
    step(2);
    chk(ckout, 8'h0, "clk stops");
    close_out();
  end
endmodule
